/* pkg/eeprom_wp_pkg.sv */
// constants, opcodes and state encoding shared by the serial eeprom write-control logic
package eeprom_wp_pkg;

    // ==================================================
    // array geometry
    localparam int ADDR_W = 13;
    localparam int MEM_BYTES = 8192;
    localparam int PAGE_BYTES = 32;
    localparam int PAGE_W = 5;
    localparam int BYTE_W = 8;
    localparam int HI_ADDR_BITS = 5;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [3:0] PIN_RST_VAL = 4'h1;

    // ==================================================
    // instruction codes, msb first on the link
    localparam logic [7:0] SET_WRITE_LATCH_INSTR = 8'h06;
    localparam logic [7:0] CLEAR_WRITE_LATCH_INSTR = 8'h04;
    localparam logic [7:0] ARRAY_WRITE_INSTR = 8'h02;
    localparam logic [7:0] ARRAY_READ_INSTR = 8'h03;
    localparam logic [7:0] STATUS_READ_INSTR = 8'h05;
    localparam logic [7:0] STATUS_WRITE_INSTR = 8'h01;

    // ==================================================
    // protect_and_status layout
    localparam int SR_BUSY_BIT = 0;
    localparam int SR_WEL_BIT = 1;
    localparam int PROTECT_LEVEL_LO = 2;
    localparam int PROTECT_LEVEL_HI = 3;
    localparam logic [3:0] SR_UPPER_VAL = 4'h0;
    localparam logic [1:0] LVL_NONE = 2'h0;
    localparam logic [1:0] LVL_QUARTER = 2'h1;
    localparam logic [1:0] LVL_HALF = 2'h2;
    localparam logic [1:0] LVL_ALL = 2'h3;
    localparam logic [ADDR_W-1:0] PROT_QUARTER_BASE = 13'h1800;
    localparam logic [ADDR_W-1:0] PROT_HALF_BASE = 13'h1000;

    // ==================================================
    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int PROG_TIME_US = 10_000;
    localparam int PROG_CYCLES_DFLT = PROG_TIME_US * (CLK_HZ / 1_000_000);

    // ==================================================
    // link sequencer states
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_OPCODE  = 3'b001,
        ST_ADDR_HI = 3'b010,
        ST_ADDR_LO = 3'b011,
        ST_WDATA   = 3'b100,
        ST_SRDATA  = 3'b101,
        ST_READOUT = 3'b110,
        ST_IGNORE  = 3'b111
    } link_state_t;

endpackage

/* design/pin_filter.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_filter #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [WIDTH-1:0] raw_i,
    output logic [WIDTH-1:0] filt_o
);

    // ==================================================
    // stage one feeds stage two only; filter looks at two and three
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] filt_ff;
    logic [WIDTH-1:0] nxt_filt;

    always_comb begin
        nxt_filt = filt_ff;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_ff[i] == s3_ff[i]) begin
                nxt_filt[i] = s3_ff[i];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_ff <= RST_VAL;
            s2_ff <= RST_VAL;
            s3_ff <= RST_VAL;
            filt_ff <= RST_VAL;
        end else begin
            s1_ff <= raw_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            filt_ff <= nxt_filt;
        end
    end

    assign filt_o = filt_ff;

endmodule

/* design/spi_eeprom_wp.sv */
// serial eeprom device: link sequencer, write latch, block protection, self-timed programming
// ==================================================
// Behaviour
// RULE1: decode 8-bit msb-first opcodes: 06 set latch, 04 clear, 02 write, 05 status read.
// RULE2: sample si on sck rise after select falls; drive so only after sck falls.
// RULE3: status byte holds level bits 3:2, latch bit 1, busy bit 0; upper four zero.
// RULE4: write latch is clear after reset; master must set it before any programming.
// RULE5: clear-latch instruction blocks array and status programming until latch set again.
// RULE6: array write accepted only with write-protect pin high and latch set.
// RULE7: array writes into the protected address range are refused.
// RULE8: level 00 none, 01 1800-1FFF, 10 1000-1FFF, 11 whole array protected.
// RULE9: master sends write opcode, high address, low address, then data bytes msb first.
// RULE10: only the low thirteen address bits are kept; top three are discarded.
// RULE11: programming starts only on select rising with sck low right after a whole byte.
// RULE12: status bit 0 reads one while programming runs, zero once it ends.
// RULE13: while programming only the status-read instruction is acted upon.
// RULE14: page write takes up to 32 bytes before select rises.
// RULE15: per byte only in-page address bits advance and wrap; extra bytes overwrite.
// RULE16: completed array write clears the write latch automatically.
// RULE17: write opcode with latch clear is discarded; standby when select rises.
// RULE18: status write keeps only data bits 3 and 2 as the new level.
// RULE19: status write accepted only with write-protect pin high and latch set.
// RULE20: status write is opcode plus one byte, then select rises to start programming.
// RULE21: completed status write clears the write latch automatically.
// RULE22: unknown opcode: no further input, so stays off until select falls again.
// RULE23: programming lasts a configurable cycle count with busy held throughout.
`timescale 1ns/1ps
module spi_eeprom_wp
    import eeprom_wp_pkg::*;
#(
    parameter int PROG_CYCLES = eeprom_wp_pkg::PROG_CYCLES_DFLT
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    input wire logic wp_n_i,
    output logic so_o,
    output logic so_oe_o,
    output logic busy_o,
    output logic wel_o,
    output logic [1:0] protect_level_o
);
    import eeprom_wp_pkg::*;

    localparam int CNT_W = $clog2(PROG_CYCLES + 1);

    // ==================================================
    // pin synchronisers
    // sampling delay is four to five clocks, which limits the usable sck rate
    logic [3:0] pins_s;
    logic cs_n_s;
    logic sck_s;
    logic si_s;
    logic wp_n_s;

    pin_filter #(
        .WIDTH(4),
        .RST_VAL(PIN_RST_VAL)
    ) u_pins (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .raw_i({wp_n_i, si_i, sck_i, cs_n_i}),
        .filt_o(pins_s)
    );

    assign cs_n_s = pins_s[0];
    assign sck_s = pins_s[1];
    assign si_s = pins_s[2];
    assign wp_n_s = pins_s[3];

    // ==================================================
    // storage: array and page load buffer, no reset on purpose
    logic [BYTE_W-1:0] mem [MEM_BYTES];
    logic [BYTE_W-1:0] page_buf [PAGE_BYTES];

    // ==================================================
    // state
    link_state_t state_ff, nxt_state;
    logic [2:0] bit_cnt_ff, nxt_bit_cnt;
    logic [2:0] out_cnt_ff, nxt_out_cnt;
    logic [BYTE_W-1:0] shift_ff, nxt_shift;
    logic [BYTE_W-1:0] out_shift_ff, nxt_out_shift;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic [PAGE_BYTES-1:0] mask_ff, nxt_mask;
    logic byte_seen_ff, nxt_byte_seen;
    logic rd_array_ff, nxt_rd_array;
    logic wel_ff, nxt_wel;
    logic [1:0] level_ff, nxt_level;
    logic [1:0] pend_level_ff, nxt_pend_level;
    logic busy_ff, nxt_busy;
    logic kind_sr_ff, nxt_kind_sr;
    logic [CNT_W-1:0] prog_cnt_ff, nxt_prog_cnt;
    logic so_ff, nxt_so;
    logic so_oe_ff, nxt_so_oe;
    logic sck_q_ff, cs_q_ff;

    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic cs_fall;
    logic [BYTE_W-1:0] rx_byte;
    logic [BYTE_W-1:0] status_val;
    logic mem_we;
    logic [ADDR_W-1:0] mem_waddr;
    logic [BYTE_W-1:0] mem_wdata;
    logic buf_we;
    logic [PAGE_W-1:0] buf_waddr;
    logic [BYTE_W-1:0] buf_wdata;

    // boundaries are page aligned, so the page base decides for every byte of a page
    function automatic logic is_protected(input logic [1:0] lvl, input logic [ADDR_W-1:0] a);
        logic hit;
        hit = 1'b0;
        unique case (lvl)
            LVL_NONE: hit = 1'b0; // [RULE8]
            LVL_QUARTER: hit = (a >= PROT_QUARTER_BASE); // [RULE8]
            LVL_HALF: hit = (a >= PROT_HALF_BASE); // [RULE8]
            LVL_ALL: hit = 1'b1; // [RULE8]
        endcase
        return hit;
    endfunction

    // ==================================================
    // edges of the filtered pins
    assign sck_rise = sck_s & ~sck_q_ff & ~cs_n_s; // [RULE2]
    assign sck_fall = ~sck_s & sck_q_ff & ~cs_n_s; // [RULE2]
    assign cs_rise = cs_n_s & ~cs_q_ff;
    assign cs_fall = ~cs_n_s & cs_q_ff;
    assign rx_byte = {shift_ff[BYTE_W-2:0], si_s};
    assign status_val = {SR_UPPER_VAL, level_ff, wel_ff, busy_ff}; // [RULE3]

    // ==================================================
    // next-state logic
    always_comb begin
        nxt_state = state_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_out_cnt = out_cnt_ff;
        nxt_shift = shift_ff;
        nxt_out_shift = out_shift_ff;
        nxt_addr = addr_ff;
        nxt_mask = mask_ff;
        nxt_byte_seen = byte_seen_ff;
        nxt_rd_array = rd_array_ff;
        nxt_wel = wel_ff;
        nxt_level = level_ff;
        nxt_pend_level = pend_level_ff;
        nxt_busy = busy_ff;
        nxt_kind_sr = kind_sr_ff;
        nxt_prog_cnt = prog_cnt_ff;
        nxt_so = so_ff;
        nxt_so_oe = so_oe_ff;
        mem_we = 1'b0;
        mem_waddr = '0;
        mem_wdata = '0;
        buf_we = 1'b0;
        buf_waddr = '0;
        buf_wdata = '0;

        // self-timed programming: commit the loaded page, then hold busy to the end
        if (busy_ff) begin
            if (!kind_sr_ff && prog_cnt_ff < CNT_W'(PAGE_BYTES) && mask_ff[prog_cnt_ff[PAGE_W-1:0]]) begin
                mem_we = 1'b1;
                mem_waddr = {addr_ff[ADDR_W-1:PAGE_W], prog_cnt_ff[PAGE_W-1:0]};
                mem_wdata = page_buf[prog_cnt_ff[PAGE_W-1:0]];
            end
            if (prog_cnt_ff == CNT_W'(PROG_CYCLES - 1)) begin
                nxt_busy = 1'b0; // [RULE12] [RULE23]
                nxt_wel = 1'b0; // [RULE16] [RULE21]
                nxt_mask = '0;
                if (kind_sr_ff) begin
                    nxt_level = pend_level_ff; // [RULE18]
                end
            end else begin
                nxt_prog_cnt = CNT_W'(prog_cnt_ff + 1'b1); // [RULE23]
            end
        end

        if (cs_n_s) begin
            nxt_state = ST_IDLE; // [RULE17]
            nxt_so_oe = 1'b0;
        end

        if (cs_rise) begin
            // a partial byte or a missing data byte starts nothing
            if (!busy_ff && !sck_s && byte_seen_ff && bit_cnt_ff == '0 && wel_ff && wp_n_s) begin // [RULE11] [RULE5]
                if (state_ff == ST_WDATA && !is_protected(level_ff, addr_ff)) begin // [RULE6] [RULE7]
                    nxt_busy = 1'b1; // [RULE12]
                    nxt_kind_sr = 1'b0;
                    nxt_prog_cnt = '0;
                end else if (state_ff == ST_SRDATA) begin // [RULE19] [RULE20]
                    nxt_busy = 1'b1; // [RULE12]
                    nxt_kind_sr = 1'b1;
                    nxt_prog_cnt = '0;
                end
            end
        end else if (cs_fall) begin
            nxt_state = ST_OPCODE; // [RULE2] [RULE22]
            nxt_bit_cnt = '0;
            nxt_byte_seen = 1'b0;
            nxt_so_oe = 1'b0;
        end else if (sck_rise && state_ff != ST_IDLE && state_ff != ST_IGNORE && state_ff != ST_READOUT) begin
            nxt_shift = rx_byte; // [RULE2]
            nxt_bit_cnt = 3'(bit_cnt_ff + 1'b1);
            if (bit_cnt_ff == LAST_BIT) begin
                unique case (state_ff)
                    ST_OPCODE: begin
                        if (rx_byte == STATUS_READ_INSTR) begin // [RULE1]
                            nxt_state = ST_READOUT;
                            nxt_rd_array = 1'b0;
                            nxt_out_shift = status_val;
                            nxt_out_cnt = '0;
                        end else if (busy_ff) begin
                            nxt_state = ST_IGNORE; // [RULE13]
                        end else begin
                            unique case (rx_byte)
                                SET_WRITE_LATCH_INSTR: begin
                                    nxt_wel = 1'b1; // [RULE1] [RULE4]
                                    nxt_state = ST_IGNORE;
                                end
                                CLEAR_WRITE_LATCH_INSTR: begin
                                    nxt_wel = 1'b0; // [RULE1] [RULE5]
                                    nxt_state = ST_IGNORE;
                                end
                                ARRAY_WRITE_INSTR: begin
                                    nxt_state = ST_ADDR_HI; // [RULE1] [RULE9]
                                    nxt_rd_array = 1'b0;
                                    nxt_mask = '0;
                                end
                                ARRAY_READ_INSTR: begin
                                    nxt_state = ST_ADDR_HI;
                                    nxt_rd_array = 1'b1;
                                end
                                STATUS_WRITE_INSTR: begin
                                    nxt_state = ST_SRDATA;
                                end
                                default: begin
                                    nxt_state = ST_IGNORE; // [RULE22]
                                end
                            endcase
                        end
                    end
                    ST_ADDR_HI: begin
                        nxt_addr[ADDR_W-1:BYTE_W] = rx_byte[HI_ADDR_BITS-1:0]; // [RULE10]
                        nxt_state = ST_ADDR_LO;
                    end
                    ST_ADDR_LO: begin
                        nxt_addr[BYTE_W-1:0] = rx_byte;
                        if (rd_array_ff) begin
                            nxt_state = ST_READOUT;
                            nxt_out_shift = mem[{addr_ff[ADDR_W-1:BYTE_W], rx_byte}];
                            nxt_out_cnt = '0;
                        end else begin
                            nxt_state = ST_WDATA;
                        end
                    end
                    ST_WDATA: begin
                        buf_we = 1'b1; // [RULE14]
                        buf_waddr = addr_ff[PAGE_W-1:0];
                        buf_wdata = rx_byte;
                        nxt_mask[addr_ff[PAGE_W-1:0]] = 1'b1; // [RULE15]
                        nxt_addr[PAGE_W-1:0] = PAGE_W'(addr_ff[PAGE_W-1:0] + 1'b1); // [RULE15]
                        nxt_byte_seen = 1'b1;
                    end
                    ST_SRDATA: begin
                        if (byte_seen_ff) begin
                            nxt_state = ST_IGNORE; // [RULE20]
                            nxt_byte_seen = 1'b0;
                        end else begin
                            nxt_pend_level = rx_byte[PROTECT_LEVEL_HI:PROTECT_LEVEL_LO]; // [RULE18]
                            nxt_byte_seen = 1'b1;
                        end
                    end
                    default: begin
                        nxt_state = ST_IGNORE;
                    end
                endcase
            end
        end else if (sck_fall && state_ff == ST_READOUT) begin
            nxt_so = out_shift_ff[BYTE_W-1]; // [RULE2]
            nxt_so_oe = 1'b1;
            nxt_out_shift = {out_shift_ff[BYTE_W-2:0], 1'b0};
            nxt_out_cnt = 3'(out_cnt_ff + 1'b1);
            if (out_cnt_ff == LAST_BIT) begin
                if (rd_array_ff) begin
                    nxt_addr = ADDR_W'(addr_ff + 1'b1);
                    nxt_out_shift = mem[ADDR_W'(addr_ff + 1'b1)];
                end else begin
                    nxt_out_shift = status_val; // [RULE12]
                end
            end
        end
    end

    // ==================================================
    // registers
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_ff <= ST_IDLE;
            bit_cnt_ff <= '0;
            out_cnt_ff <= '0;
            shift_ff <= '0;
            out_shift_ff <= '0;
            addr_ff <= '0;
            mask_ff <= '0;
            byte_seen_ff <= 1'b0;
            rd_array_ff <= 1'b0;
            wel_ff <= 1'b0; // [RULE4]
            level_ff <= LVL_NONE;
            pend_level_ff <= LVL_NONE;
            busy_ff <= 1'b0;
            kind_sr_ff <= 1'b0;
            prog_cnt_ff <= '0;
            so_ff <= 1'b0;
            so_oe_ff <= 1'b0;
            sck_q_ff <= 1'b0;
            cs_q_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            bit_cnt_ff <= nxt_bit_cnt;
            out_cnt_ff <= nxt_out_cnt;
            shift_ff <= nxt_shift;
            out_shift_ff <= nxt_out_shift;
            addr_ff <= nxt_addr;
            mask_ff <= nxt_mask;
            byte_seen_ff <= nxt_byte_seen;
            rd_array_ff <= nxt_rd_array;
            wel_ff <= nxt_wel;
            level_ff <= nxt_level;
            pend_level_ff <= nxt_pend_level;
            busy_ff <= nxt_busy;
            kind_sr_ff <= nxt_kind_sr;
            prog_cnt_ff <= nxt_prog_cnt;
            so_ff <= nxt_so;
            so_oe_ff <= nxt_so_oe;
            sck_q_ff <= sck_s;
            cs_q_ff <= cs_n_s;
        end
    end

    always_ff @(posedge clk_i) begin
        if (mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
        if (buf_we) begin
            page_buf[buf_waddr] <= buf_wdata;
        end
    end

    assign so_o = so_ff;
    assign so_oe_o = so_oe_ff;
    assign busy_o = busy_ff;
    assign wel_o = wel_ff;
    assign protect_level_o = level_ff;

endmodule

/* dv/eeprom_wp_asserts.sv */
// concurrent checks on the ports of the serial eeprom write-control block
`timescale 1ns/1ps
module eeprom_wp_asserts #(
    parameter int PROG_CYCLES = 64
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    input wire logic wp_n_i,
    input wire logic so_o,
    input wire logic so_oe_o,
    input wire logic busy_o,
    input wire logic wel_o,
    input wire logic [1:0] protect_level_o
);
    // ==================================================
    // busy length counter
    logic [31:0] busy_cnt_ff;
    logic [31:0] nxt_busy_cnt;

    always_comb begin
        nxt_busy_cnt = busy_o ? busy_cnt_ff + 32'h1 : 32'h0;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_cnt_ff <= 32'h0;
        end else begin
            busy_cnt_ff <= nxt_busy_cnt;
        end
    end

    // ==================================================
    // properties
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    // select must stay high a while before the output driver may be trusted off
    sequence cs_idle;
        cs_n_i [*8];
    endsequence
    sequence prog_start;
        $rose(busy_o);
    endsequence
    sequence prog_end;
        $fell(busy_o);
    endsequence

    reset_values_a: assert property ($rose(rstn_i) |-> !busy_o && !wel_o && protect_level_o == 2'h0)
        else $error("state not cleared after reset");
    busy_start_a: assert property (prog_start |-> cs_n_i && $past(cs_n_i, 3) && !sck_i)
        else $error("programming began without select rise");
    busy_len_a: assert property (prog_end |-> busy_cnt_ff == PROG_CYCLES)
        else $error("programming time wrong");
    busy_bound_a: assert property (busy_o |-> busy_cnt_ff < PROG_CYCLES)
        else $error("busy held too long");
    wel_auto_clear_a: assert property (prog_end |-> !wel_o)
        else $error("latch kept after programming");
    wel_rise_a: assert property ($rose(wel_o) |-> !cs_n_i && !busy_o)
        else $error("latch set outside a frame");
    wel_fall_a: assert property ($fell(wel_o) |-> $fell(busy_o) || !cs_n_i)
        else $error("latch cleared without cause");
    level_change_a: assert property ($changed(protect_level_o) |-> $fell(busy_o))
        else $error("level changed outside programming end");
    busy_needs_wel_a: assert property (prog_start |-> wel_o && wp_n_i)
        else $error("programming without latch or with protect pin low");
    so_quiet_a: assert property (cs_idle |-> !so_oe_o)
        else $error("output driven while deselected");
    so_start_a: assert property ($rose(so_oe_o) |-> !sck_i && !cs_n_i)
        else $error("output driven outside clock low");
endmodule

/* dv/spi_master_model.sv */
// spi master model driving select, clock and data into the eeprom
`timescale 1ns/1ps
module spi_master_model #(
    parameter int HALF = 8
) (
    input wire logic clk_i,
    input wire logic so_i,
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o
);
    logic [7:0] rx_q[$];

    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
    end

    task automatic half_wait();
        repeat (HALF) @(negedge clk_i);
    endtask

    // ==================================================
    // one frame: bytes out, spare pulses, bytes read back
    task automatic xfer(input logic [7:0] tx[$], input int extra, input int nrd);
        logic [7:0] b;
        rx_q.delete();
        @(negedge clk_i);
        cs_n_o = 1'b0; // clock rests low when select falls
        foreach (tx[i]) begin
            for (int k = 7; k >= 0; k--) begin
                sck_o = 1'b0;
                si_o = tx[i][k]; // msb first
                half_wait();
                sck_o = 1'b1;
                half_wait();
            end
        end
        for (int k = 0; k < extra; k++) begin
            sck_o = 1'b0;
            si_o = 1'b1;
            half_wait();
            sck_o = 1'b1;
            half_wait();
        end
        for (int n = 0; n < nrd; n++) begin
            for (int k = 7; k >= 0; k--) begin
                sck_o = 1'b0;
                half_wait();
                b[k] = so_i; // taken late in clock low
                sck_o = 1'b1;
                half_wait();
            end
            rx_q.push_back(b);
        end
        sck_o = 1'b0;
        half_wait();
        cs_n_o = 1'b1; // rise in clock-low time right after the last bit
        si_o = ~si_o; // released line must not look held
        half_wait();
    endtask
endmodule

/* dv/serial_eeprom_write_protect_tb.sv */
// self-checking bench for the serial eeprom write-control block
`timescale 1ns/1ps
module serial_eeprom_write_protect_tb;
    import eeprom_wp_pkg::*;
    localparam int PROG = 600;
    logic clk, rstn, wp_n, so, so_oe, busy, wel, so_last, so_line, cs_n, sck, si;
    logic [1:0] level, exp_lvl;
    logic exp_wel;
    logic [31:0] rng;
    logic [7:0] exp_mem [int];
    logic [7:0] d[$];
    int errors, checks, cycles, oe_hits;

    spi_eeprom_wp #(.PROG_CYCLES(PROG)) dut_u (.clk_i(clk), .rstn_i(rstn), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
        .wp_n_i(wp_n), .so_o(so), .so_oe_o(so_oe), .busy_o(busy), .wel_o(wel), .protect_level_o(level));
    spi_master_model master_u (.clk_i(clk), .so_i(so_line), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));

    // undriven line shows the inverse of its last value
    assign so_line = so_oe ? so : ~so_last;

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (so_oe === 1'b1) begin
            so_last <= so;
            oe_hits++;
        end
        if (cycles == 60000) begin
            errors++;
            report_and_stop();
        end
    end

    // ==================================================
    // helpers
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    function automatic logic hit(input logic [1:0] lv, input logic [12:0] a);
        return (lv == 2'h3) || (lv == 2'h2 && a >= 13'h1000) || (lv == 2'h1 && a >= 13'h1800);
    endfunction

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        if (errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic set_latch();
        master_u.xfer('{SET_WRITE_LATCH_INSTR}, 0, 0);
        exp_wel = 1'b1;
        check("latch set", wel, exp_wel);
    endtask

    task automatic status_is(input logic bsy);
        master_u.xfer('{STATUS_READ_INSTR}, 0, 1);
        check("status", master_u.rx_q[0], {4'h0, exp_lvl, exp_wel, bsy});
    endtask

    // read status once while busy, try a latch clear, then wait on busy for the end
    task automatic busy_phase(input logic [1:0] nl);
        int n;
        status_is(1'b1);
        master_u.xfer('{CLEAR_WRITE_LATCH_INSTR}, 0, 0);
        check("latch while busy", wel, 1'b1);
        n = 0;
        while (busy !== 1'b0 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        exp_wel = 1'b0;
        exp_lvl = nl;
        status_is(1'b0);
    endtask

    task automatic write_try(input logic [15:0] a, input int extra, input logic go);
        logic [7:0] q[$];
        q = {ARRAY_WRITE_INSTR, a[15:8], a[7:0]};
        q = {q, d};
        master_u.xfer(q, extra, 0);
        check("write start", busy, go);
        check("latch after write frame", wel, exp_wel);
        if (go) begin
            foreach (d[i]) exp_mem[{a[12:5], 5'(a[4:0] + 5'(i))}] = d[i];
            busy_phase(exp_lvl);
        end
    endtask

    task automatic status_try(input logic [7:0] v, input logic go);
        master_u.xfer('{STATUS_WRITE_INSTR, v}, 0, 0);
        check("status write start", busy, go);
        if (go) begin
            busy_phase(v[3:2]);
        end
        check("level", level, exp_lvl);
    endtask

    // ==================================================
    // main sequence
    initial begin
        logic [15:0] a;
        logic [15:0] tgt[4];
        logic [7:0] bad[3];
        rng = 32'h299E;
        so_last = 1'b0;
        wp_n = 1'b1;
        rstn = 1'b0;
        exp_lvl = 2'h0;
        exp_wel = 1'b0;
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        repeat (8) @(negedge clk);
        check("reset busy", busy, 1'b0);
        check("reset latch", wel, 1'b0);
        status_is(1'b0);
        d = '{8'hA5};
        write_try(16'h0040, 0, 1'b0);
        status_try(8'h0C, 1'b0);
        set_latch();
        master_u.xfer('{CLEAR_WRITE_LATCH_INSTR}, 0, 0);
        exp_wel = 1'b0;
        check("latch cleared", wel, 1'b0);
        write_try(16'h0040, 0, 1'b0);
        status_try(8'h0C, 1'b0);
        set_latch();
        wp_n = 1'b0;
        repeat (8) @(negedge clk);
        write_try(16'h0040, 0, 1'b0);
        status_try(8'h0C, 1'b0);
        wp_n = 1'b1;
        repeat (8) @(negedge clk);
        write_try(16'h0040, 3, 1'b0);
        // 34 bytes: the last two wrap onto the first two written, at the start offset of a
        d.delete();
        repeat (34) d.push_back(8'(rnd()));
        a = 16'(rnd());
        write_try(a, 0, 1'b1);
        master_u.xfer('{ARRAY_READ_INSTR, {3'h0, a[12:8]}, {a[7:5], 5'h0}}, 0, 32);
        for (int i = 0; i < 32; i++) begin
            check("page byte", master_u.rx_q[i], exp_mem[{a[12:5], 5'(i)}]);
        end
        tgt = '{16'h0FE0, 16'h1000, 16'h17E0, 16'h1800};
        for (int lv = 1; lv < 4; lv++) begin
            set_latch();
            status_try({4'(rnd()), 2'(lv), 2'(rnd())}, 1'b1);
            foreach (tgt[j]) begin
                set_latch();
                d = '{8'(rnd())};
                write_try({3'(rnd()), tgt[j][12:0]}, 0, !hit(2'(lv), tgt[j][12:0]));
            end
        end
        set_latch();
        status_try(8'hF3, 1'b1);
        bad = '{8'hFF, 8'h00, 8'h85};
        foreach (bad[j]) begin
            oe_hits = 0;
            master_u.xfer('{bad[j], SET_WRITE_LATCH_INSTR}, 0, 1);
            check("drive after bad opcode", 8'(oe_hits), 8'h00);
            check("latch after bad opcode", wel, 1'b0);
        end
        report_and_stop();
    end
endmodule

bind spi_eeprom_wp eeprom_wp_asserts #(.PROG_CYCLES(PROG_CYCLES)) asserts_u (.clk_i(clk_i), .rstn_i(rstn_i),
    .cs_n_i(cs_n_i), .sck_i(sck_i), .si_i(si_i), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o),
    .busy_o(busy_o), .wel_o(wel_o), .protect_level_o(protect_level_o));
